// ==== bench/scc_ctrl_chk.sv ====
`timescale 1ns/1ps
// ----
// Port checks
// ----
module scc_ctrl_chk (
  input logic SYS_CLK, // Clock
  input logic NRST, // Reset
  input logic PSEL, // Select
  input logic PENABLE, // Enable
  input logic PWRITE, // Direction
  input logic [7:0] PADDR, // Address
  input logic [31:0] PWDATA, // Write data
  input logic PREADY, // Ready
  input logic PSLVERR, // Error
  input logic CPU_REQ, // Request
  input logic CPU_READY, // Taken
  input logic CPU_ACK, // Done
  input logic [31:0] CPU_RDATA, // Data
  input logic PRB_REQ, // Probe
  input logic PRB_READY, // Probe taken
  input logic PRB_ACK, // Probe done
  input logic MEM_REQ, // Memory request
  input logic MEM_WE, // Memory write
  input logic [31:0] MEM_ADDR, // Memory address
  input logic MEM_ACK // Memory done
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  wire acc = PSEL && PENABLE && PREADY; // Completing access
  wire take = CPU_REQ && CPU_READY; // Request taken
  wire ptake = PRB_REQ && PRB_READY; // Probe taken
  // Register bus
  a_apb_no_wait: assert property (PSEL && !PENABLE |=> PREADY) else $error("ready late");
  a_mode_fault: assert property (acc && PWRITE && PADDR == 8'h0 && !PWDATA[30] && PWDATA[29] |-> PSLVERR)
    else $error("mode not refused");
  a_unmapped_err: assert property (acc && PADDR > 8'h14 |-> PSLVERR) else $error("unmapped accepted");
  // Requests and memory
  a_cpu_busy: assert property (take |=> !CPU_READY) else $error("ready while busy");
  a_cpu_ack_time: assert property (take |=> !CPU_ACK [*2] ##[1:400] CPU_ACK) else $error("ack timing");
  a_rdata_hold: assert property ($changed(CPU_RDATA) |-> CPU_ACK) else $error("data moved");
  a_mem_aligned: assert property (MEM_REQ |-> MEM_ADDR[1:0] == 2'h0) else $error("address unaligned");
  a_mem_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE))
    else $error("memory request moved");
  a_probe_first: assert property (ptake |-> !CPU_READY) else $error("probe not first");
  a_probe_ack: assert property (ptake |=> !PRB_ACK ##[1:400] PRB_ACK) else $error("probe ack timing");
  // Main scenarios
  c_refused: cover property (acc && PSLVERR);
  c_mem_write: cover property (MEM_REQ && MEM_WE && MEM_ACK);
  c_probe: cover property (PRB_ACK);
endmodule

// ==== bench/scc_ctrl_tb.sv ====
`timescale 1ns/1ps
module scc_ctrl_tb;
  // ----
  // Stimulus, design and memory
  // ----
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, creq = 1'b0, page_cache_disable = 1'b0, page_writethrough = 1'b0;
  logic preq = 1'b0, pinv = 1'b0, prdy, perr, crdy, cack, prrdy, pack, phit, mreq, mwe, mack, irq, er, hit;
  logic [7:0] pad = 8'h0;
  logic [1:0] cop = 2'h0;
  logic [2:0] rty = 3'h4;
  logic [3:0] mbe;
  logic [31:0] pwd = 32'h0, cad = 32'h0, cwd = 32'h0, pra = 32'h0, prd, crd, mad, mwd, mrd, rd, dat;
  int lat = 1, nrd, nwr, r0, w0, miscompares = 0, checked = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  scc_ctrl scc_ctrl_inst (.SYS_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pad),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .CPU_REQ(creq), .CPU_OP(cop), .CPU_ADDR(cad),
    .CPU_WDATA(cwd), .CPU_BE(4'hF), .CPU_WALK(1'b0), .CPU_PAGE_CD(page_cache_disable), .CPU_PAGE_WT(page_writethrough), .CPU_RANGE_TYPE(rty),
    .CPU_READY(crdy), .CPU_ACK(cack), .CPU_RDATA(crd), .PRB_REQ(preq), .PRB_ADDR(pra), .PRB_INV(pinv),
    .PRB_READY(prrdy), .PRB_ACK(pack), .PRB_HIT(phit), .MEM_REQ(mreq), .MEM_WE(mwe), .MEM_ADDR(mad),
    .MEM_BE(mbe), .MEM_WDATA(mwd), .MEM_ACK(mack), .MEM_RDATA(mrd), .IRQ(irq));
  scc_mem_model scc_mem_model_inst (.clk(clk), .lat(lat), .req(mreq), .we(mwe), .addr(mad), .be(mbe),
    .wdata(mwd), .ack(mack), .rdata(mrd), .nrd(nrd), .nwr(nwr));
  // ----
  // Bus tasks and checks
  // ----
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One edge; a wait past the bound ends the run
  task tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 400) begin
      miscompares++;
      tally_and_finish;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pad <= a;
    pwd <= d;
    tick(n);
    pen <= 1'b1;
    do tick(n); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    tick(n);
  endtask
  task cpu(input logic [1:0] o, input logic [11:0] a, input logic [31:0] d, input logic c, input logic w);
    int n;
    n = 0;
    creq <= 1'b1;
    cop <= o;
    cad <= {20'h0, a};
    cwd <= d;
    page_cache_disable <= c;
    page_writethrough <= w;
    do tick(n); while (crdy !== 1'b1);
    creq <= 1'b0;
    do tick(n); while (cack !== 1'b1);
    dat = crd;
  endtask
  task ld(input logic [11:0] a);
    cpu(2'h0, a, 32'h0, 1'b0, 1'b0);
  endtask
  task fe(input logic [11:0] a);
    cpu(2'h2, a, 32'h0, 1'b0, 1'b0);
  endtask
  task prb(input logic [11:0] a, input logic i);
    int n;
    n = 0;
    preq <= 1'b1;
    pra <= {20'h0, a};
    pinv <= i;
    do tick(n); while (prrdy !== 1'b1);
    preq <= 1'b0;
    do tick(n); while (pack !== 1'b1);
    hit = phit;
  endtask
  // Memory traffic since the last snapshot
  task snap;
    r0 = nrd;
    w0 = nwr;
  endtask
  task dm(input int r, input int w);
    chk("mem reads", nrd - r0, r);
    chk("mem writes", nwr - w0, w);
  endtask
  function automatic logic [31:0] mw(input logic [11:0] a);
    return 32'h5A00_0000 | {24'h0, a[9:2]};
  endfunction
  // ----
  // Scenarios
  // ----
  task s_mode;
    apb(1'b0, 8'h0, 32'h0);
    chk("ctrl reset", rd, 32'h6000_0000);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", er, 1'b1);
    apb(1'b1, 8'h10, 32'h2);
    apb(1'b1, 8'h0, 32'h2000_0000);
    chk("mode err", er, 1'b1);
    chk("mode irq", irq, 1'b1);
    apb(1'b0, 8'h0, 32'h0);
    chk("ctrl kept", rd, 32'h6000_0000);
    apb(1'b0, 8'h0C, 32'h0);
    chk("fault stat", rd[1], 1'b1);
    chk("irq clear", irq, 1'b0);
    apb(1'b1, 8'h0, 32'h4000_0000);
    chk("cd only", er, 1'b0);
  endtask
  task s_types;
    apb(1'b1, 8'h08, 32'h800);
    snap;
    ld(12'h010);
    chk("off data", dat, mw(12'h010));
    ld(12'h010);
    dm(2, 0);
    apb(1'b1, 8'h0, 32'h0);
    apb(1'b1, 8'h08, 32'h0);
    snap;
    ld(12'h014);
    ld(12'h014);
    dm(2, 0);
    apb(1'b1, 8'h08, 32'h800);
  endtask
  task s_hit;
    lat <= 3;
    snap;
    ld(12'h004);
    ld(12'h005);
    chk("offset data", dat, mw(12'h004) >> 8);
    ld(12'h044);
    ld(12'h004);
    dm(2, 0);
    ld(12'h084);
    chk("victim fill", dat, mw(12'h084));
    dm(3, 0);
  endtask
  task s_pol;
    ld(12'h00C);
    snap;
    cpu(2'h1, 12'h00C, 32'h1111_2222, 1'b0, 1'b1);
    dm(0, 1);
    rty <= 3'h3;
    cpu(2'h1, 12'h00C, 32'h3333_4444, 1'b0, 1'b0);
    dm(0, 2);
    rty <= 3'h4;
    cpu(2'h1, 12'h00C, 32'h5555_6666, 1'b1, 1'b1);
    dm(0, 3);
    ld(12'h00C);
    chk("refill", dat, 32'h5555_6666);
    cpu(2'h1, 12'h00C, 32'h7777_8888, 1'b0, 1'b0);
    dm(1, 3);
    apb(1'b1, 8'h0, 32'h4000_0000);
    ld(12'h00C);
    chk("flushed", dat, 32'h7777_8888);
    dm(2, 4);
  endtask
  task s_smc;
    apb(1'b1, 8'h0, 32'h0);
    fe(12'h018);
    snap;
    fe(12'h018);
    dm(0, 0);
    cpu(2'h1, 12'h018, 32'h9999_AAAA, 1'b0, 1'b0);
    fe(12'h018);
    chk("new code", dat, 32'h9999_AAAA);
    apb(1'b0, 8'h0C, 32'h0);
    chk("smc stat", rd[2], 1'b1);
    fe(12'h01C);
    apb(1'b1, 8'h0, 32'h4000_0000);
    snap;
    fe(12'h01C);
    chk("icache", dat, mw(12'h01C));
    dm(0, 0);
    apb(1'b1, 8'h0, 32'h0);
  endtask
  task s_prb;
    lat <= 0;
    cpu(2'h1, 12'h020, 32'hBBBB_CCCC, 1'b0, 1'b0);
    snap;
    prb(12'h020, 1'b0);
    chk("probe hit", hit, 1'b1);
    ld(12'h020);
    dm(0, 1);
    prb(12'h020, 1'b1);
    ld(12'h020);
    chk("probe data", dat, 32'hBBBB_CCCC);
    dm(1, 1);
    prb(12'h3E0, 1'b1);
    chk("probe miss", hit, 1'b0);
  endtask
  // Reset for three cycles, then every scenario
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    s_mode;
    s_types;
    s_hit;
    s_pol;
    s_smc;
    s_prb;
    tally_and_finish;
  end
endmodule
bind scc_ctrl scc_ctrl_chk scc_ctrl_chk_inst (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CPU_REQ(CPU_REQ),
  .CPU_READY(CPU_READY), .CPU_ACK(CPU_ACK), .CPU_RDATA(CPU_RDATA), .PRB_REQ(PRB_REQ), .PRB_READY(PRB_READY),
  .PRB_ACK(PRB_ACK), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK));

// ==== bench/scc_mem_model.sv ====
`timescale 1ns/1ps
// ----
// Main memory
// ----
module scc_mem_model (
  input logic clk, // Clock
  input int lat, // Wait cycles
  input logic req, // Request
  input logic we, // Write
  input logic [31:0] addr, // Word address
  input logic [3:0] be, // Lanes
  input logic [31:0] wdata, // Write data
  output logic ack, // Done pulse
  output logic [31:0] rdata, // Read data
  output int nrd, // Reads done
  output int nwr // Writes done
);
  logic [31:0] m [256];
  int cnt = 0;
  // Known pattern, word index in low byte
  initial begin
    ack = 1'b0;
    rdata = 32'h0;
    nrd = 0;
    nwr = 0;
    for (int i = 0; i < 256; i++) m[i] = 32'h5A00_0000 | 32'(i);
  end
  // Answer after lat waits; stale read data toggles
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack) begin
      if (cnt < lat) begin
        cnt++;
      end else begin
        cnt = 0;
        ack <= 1'b1;
        if (we) begin
          for (int b = 0; b < 4; b++) if (be[b]) m[addr[9:2]][8*b+:8] = wdata[8*b+:8];
          nwr <= nwr + 1;
        end else begin
          rdata <= m[addr[9:2]];
          nrd <= nrd + 1;
        end
      end
    end
  end
endmodule

// ==== common/scc_consts.svh ====
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCC_OFF_CTRL 8'h00
`define SCC_OFF_TBASE 8'h04
`define SCC_OFF_RANGE 8'h08
`define SCC_OFF_IRQST 8'h0C
`define SCC_OFF_IRQMSK 8'h10
`define SCC_OFF_STAT 8'h14
// ----------------------------------------
// Field positions, masks, reset values
// ----------------------------------------
`define SCC_BIT_CD 30
`define SCC_BIT_NW 29
`define SCC_BIT_PCD 4
`define SCC_BIT_PWT 3
`define SCC_BIT_RNGEN 11
`define SCC_CTRL_MASK 32'h6000_0000
`define SCC_RANGE_MASK 32'h0000_0800
`define SCC_RST_CTRL 32'h6000_0000
`define SCC_RST_TBASE 32'h0000_0000
`define SCC_RST_RANGE 32'h0000_0000
`define SCC_OFS_W 2
`define SCC_BE_ALL 4'hF
// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define SCC_IRQ_W 4
`define SCC_IRQ_MISS 0
`define SCC_IRQ_FAULT 1
`define SCC_IRQ_SMC 2
`define SCC_IRQ_PWB 3
`endif

// ==== common/scc_pkg.sv ====
package scc_pkg;
  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOK = 3'b001,
    ST_WBACK = 3'b010,
    ST_FILL = 3'b011,
    ST_MEM = 3'b100,
    ST_DONE = 3'b101,
    ST_PROBE = 3'b110
  } scc_state_t;
  // Request kinds
  typedef enum logic [1:0] {
    OP_LOAD = 2'b00,
    OP_STORE = 2'b01,
    OP_FETCH = 2'b10,
    OP_PROBE = 2'b11
  } scc_op_t;
  // Memory types, most restrictive lowest
  typedef enum logic [2:0] {
    TYPE_UNCACHEABLE = 3'b000,
    TYPE_WRITE_COMBINING = 3'b001,
    TYPE_WRITE_PROTECTED = 3'b010,
    TYPE_WRITETHROUGH = 3'b011,
    TYPE_WRITEBACK = 3'b100
  } scc_mtype_t;
endpackage

// ==== design/scc_ctrl.sv ====
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`include "scc_consts.svh"

// Behaviour
// - Sets of n ways, line holds data/tag/state
// - Lookup uses physical address index/tag/offset
// - Index selects set, all ways compared
// - Tag match gives hit and way
// - Hit data accessed at offset byte
// - Data writes invalidate matching instruction lines, prefetch
// - Write probes use physical address only
// - Cacheable fetch takes newest copy from data cache
// - Global disable bit 30 bypasses caching
// - Disabled load/store hit: writeback dirty, invalidate, uncached access
// - Disabled fetch hit served from instruction cache
// - Probes answered; invalidate only for write/exclusive
// - Bit 29 set with caching enabled faults
// - Page disable bit 4 makes uncacheable
// - Page bit 3 selects writethrough policy
// - Writethrough only when page disable clear
// - Range registers off means uncacheable default
// - Most restrictive memory type wins
module scc_ctrl #(
  parameter int IDX_W = 4, // Index field width
  parameter int WAYS = 2,  // Ways per set
  parameter int MC_W = 16  // Miss counter width
) (
  input logic SYS_CLK,           // Core clock
  input logic NRST,              // Sync reset, low
  input logic PSEL,              // APB select
  input logic PENABLE,           // APB enable
  input logic PWRITE,            // APB direction
  input logic [7:0] PADDR,       // APB address
  input logic [31:0] PWDATA,     // APB write data
  output logic [31:0] PRDATA,    // APB read data
  output logic PREADY,           // APB ready
  output logic PSLVERR,          // APB error
  input logic CPU_REQ,           // Access request
  input logic [1:0] CPU_OP,      // Load, store, fetch
  input logic [31:0] CPU_ADDR,   // Physical address
  input logic [31:0] CPU_WDATA,  // Store data, low aligned
  input logic [3:0] CPU_BE,      // Store lanes, low aligned
  input logic CPU_WALK,          // Top table access
  input logic CPU_PAGE_CD,       // page_cache_disable
  input logic CPU_PAGE_WT,       // page_writethrough
  input logic [2:0] CPU_RANGE_TYPE, // Range memory type
  output logic CPU_READY,        // Request taken
  output logic CPU_ACK,          // Access done
  output logic [31:0] CPU_RDATA, // Load/fetch data
  input logic PRB_REQ,           // Coherence probe
  input logic [31:0] PRB_ADDR,   // Probe address
  input logic PRB_INV,           // Write or exclusive read
  output logic PRB_READY,        // Probe taken
  output logic PRB_ACK,          // Probe done
  output logic PRB_HIT,          // Probe hit
  output logic MEM_REQ,          // Memory request
  output logic MEM_WE,           // Memory write
  output logic [31:0] MEM_ADDR,  // Word address
  output logic [3:0] MEM_BE,     // Byte lanes
  output logic [31:0] MEM_WDATA, // Write data
  input logic MEM_ACK,           // Memory done
  input logic [31:0] MEM_RDATA,  // Read data
  output logic IRQ               // Interrupt level
);
  localparam int SETS = 1 << IDX_W;
  localparam int N = SETS * WAYS;
  localparam int SW = (N > 1) ? $clog2(N) : 1;
  localparam int WW = (WAYS > 1) ? $clog2(WAYS) : 1;
  localparam int OW = `SCC_OFS_W;
  localparam int TAG_W = 32 - IDX_W - OW;
  localparam int IW = `SCC_IRQ_W;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [SW-1:0] slot(input logic [IDX_W-1:0] s, input logic [WW-1:0] w);
    slot = SW'(int'(s) * WAYS + int'(w));
  endfunction

  function automatic logic [WW-1:0] first_set(input logic [WAYS-1:0] v);
    first_set = '0;
    for (int k = WAYS - 1; k >= 0; k--) begin
      if (v[k]) first_set = WW'(k);
    end
  endfunction

  function automatic logic [WW-1:0] nxt_way(input logic [WW-1:0] w);
    nxt_way = (w == WW'(WAYS - 1)) ? '0 : w + 1'b1;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) merge[8*b +: 8] = n[8*b +: 8];
    end
  endfunction

  function automatic logic [31:0] line_addr(input logic [TAG_W-1:0] t, input logic [IDX_W-1:0] s);
    line_addr = {t, s, {OW{1'b0}}};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  scc_pkg::scc_state_t st_r;
  scc_pkg::scc_op_t op_r;
  logic [31:0] addr_r, wdat_r, res_r, pf_addr_r, pf_dat_r;
  logic [3:0] be_r;
  logic [2:0] mt_r;
  logic cch_r, inv_r, fill_r, pf_val_r;
  logic [WW-1:0] vw_r;
  logic [TAG_W-1:0] d_tag_r [N];
  logic [TAG_W-1:0] i_tag_r [N];
  logic [31:0] d_dat_r [N];
  logic [31:0] i_dat_r [N];
  logic [N-1:0] d_val_r, d_dty_r, i_val_r;
  logic [WW-1:0] rr_r [SETS];
  logic mem_req_r, mem_we_r, cpu_ack_r, prb_ack_r, prb_hit_r;
  logic [31:0] mem_addr_r, mem_wdat_r, cpu_rdat_r;
  logic [3:0] mem_be_r;
  logic [IW-1:0] ev_r, irq_st_r, irq_msk_r;
  logic [31:0] ctrl_r, tbase_r, rng_r, prdata_r;
  logic pready_r, pslverr_r;
  logic [MC_W-1:0] miss_cnt_r;

  // ----------------------------------------
  // Address split and lookup
  // ----------------------------------------
  wire [IDX_W-1:0] a_idx = addr_r[OW +: IDX_W];
  wire [TAG_W-1:0] a_tag = addr_r[31 -: TAG_W];
  wire [OW-1:0] a_ofs = addr_r[OW-1:0];
  logic [WAYS-1:0] d_hitv, i_hitv, d_vset, i_vset;

  // Parallel tag compare across every way of the set
  for (genvar g = 0; g < WAYS; g++) begin : g_way
    wire [SW-1:0] s = slot(a_idx, WW'(g));
    assign d_vset[g] = d_val_r[s];
    assign i_vset[g] = i_val_r[s];
    assign d_hitv[g] = d_vset[g] && (d_tag_r[s] == a_tag);
    assign i_hitv[g] = i_vset[g] && (i_tag_r[s] == a_tag);
  end

  // Hit way, victim way, slots
  wire d_hit = |d_hitv;
  wire i_hit = |i_hitv;
  wire [WW-1:0] d_way = first_set(d_hitv);
  wire [WW-1:0] i_way = first_set(i_hitv);
  wire [SW-1:0] d_slot = slot(a_idx, d_way);
  wire [SW-1:0] i_slot = slot(a_idx, i_way);
  wire [WW-1:0] d_vic = (&d_vset) ? rr_r[a_idx] : first_set(~d_vset);
  wire [WW-1:0] i_vic = (&i_vset) ? rr_r[a_idx] : first_set(~i_vset);
  wire [SW-1:0] dv_slot = slot(a_idx, d_vic);
  wire [SW-1:0] iv_slot = slot(a_idx, i_vic);
  wire [SW-1:0] v_slot = slot(a_idx, vw_r);
  wire pf_hit = pf_val_r && (pf_addr_r[31:OW] == addr_r[31:OW]);
  wire is_st = op_r == scc_pkg::OP_STORE;
  wire is_wb = mt_r == scc_pkg::TYPE_WRITEBACK;
  wire [3:0] unc_be = is_st ? be_r : `SCC_BE_ALL;

  // ----------------------------------------
  // Memory type of an incoming request
  // ----------------------------------------
  wire cd = ctrl_r[`SCC_BIT_CD];
  wire pg_cd = CPU_WALK ? tbase_r[`SCC_BIT_PCD] : CPU_PAGE_CD;
  wire pg_wt = CPU_WALK ? tbase_r[`SCC_BIT_PWT] : CPU_PAGE_WT;
  wire [2:0] pg_type = pg_cd ? scc_pkg::TYPE_UNCACHEABLE :
    (pg_wt ? scc_pkg::TYPE_WRITETHROUGH : scc_pkg::TYPE_WRITEBACK);
  wire rng_bad = CPU_RANGE_TYPE > scc_pkg::TYPE_WRITEBACK;
  wire [2:0] rng_type = (!rng_r[`SCC_BIT_RNGEN] || rng_bad) ? scc_pkg::TYPE_UNCACHEABLE : CPU_RANGE_TYPE;
  wire [2:0] eff_type = (pg_type < rng_type) ? pg_type : rng_type;
  wire eff_cch = !cd && (eff_type >= scc_pkg::TYPE_WRITE_PROTECTED);
  wire [4:0] sh = {CPU_ADDR[OW-1:0], 3'b000};

  // Launch a memory transaction and move on
  task automatic go_mem(input logic we, input logic [31:0] ad, input logic [3:0] be, input logic [31:0] dt,
                        input scc_pkg::scc_state_t ns);
    mem_req_r <= 1'b1;
    mem_we_r <= we;
    mem_addr_r <= {ad[31:OW], {OW{1'b0}}};
    mem_be_r <= be;
    mem_wdat_r <= dt;
    st_r <= ns;
  endtask

  // ----------------------------------------
  // Access controller
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      st_r <= scc_pkg::ST_IDLE;
      op_r <= scc_pkg::OP_LOAD;
      {addr_r, wdat_r, res_r, pf_addr_r, pf_dat_r} <= '0;
      {be_r, mt_r, cch_r, inv_r, fill_r, pf_val_r, vw_r} <= '0;
      {d_val_r, d_dty_r, i_val_r} <= '0;
      {mem_req_r, mem_we_r, mem_addr_r, mem_be_r, mem_wdat_r} <= '0;
      {cpu_ack_r, cpu_rdat_r, prb_ack_r, prb_hit_r, ev_r} <= '0;
      for (int s = 0; s < SETS; s++) begin
        rr_r[s] <= '0;
      end
    end else begin
      cpu_ack_r <= 1'b0;
      prb_ack_r <= 1'b0;
      ev_r <= '0;
      case (st_r)
        scc_pkg::ST_IDLE: begin
          if (PRB_REQ) begin
            op_r <= scc_pkg::OP_PROBE;
            addr_r <= PRB_ADDR;
            inv_r <= PRB_INV;
            st_r <= scc_pkg::ST_PROBE;
          end else if (CPU_REQ) begin
            op_r <= scc_pkg::scc_op_t'(CPU_OP);
            addr_r <= CPU_ADDR;
            wdat_r <= CPU_WDATA << sh;
            be_r <= CPU_BE << CPU_ADDR[OW-1:0];
            mt_r <= eff_type;
            cch_r <= eff_cch;
            st_r <= scc_pkg::ST_LOOK;
          end
        end
        scc_pkg::ST_LOOK: begin
          // Store snoops instruction side by physical address
          if (is_st && i_hit) i_val_r[i_slot] <= 1'b0;
          if (is_st && pf_hit) pf_val_r <= 1'b0;
          ev_r[`SCC_IRQ_SMC] <= is_st && (i_hit || pf_hit);
          if (op_r == scc_pkg::OP_FETCH) begin
            if (i_hit) begin
              res_r <= i_dat_r[i_slot];
              st_r <= scc_pkg::ST_DONE;
            end else if (pf_hit) begin
              res_r <= pf_dat_r;
              st_r <= scc_pkg::ST_DONE;
            end else if (cch_r && d_hit) begin
              i_tag_r[iv_slot] <= a_tag;
              i_dat_r[iv_slot] <= d_dat_r[d_slot];
              i_val_r[iv_slot] <= 1'b1;
              rr_r[a_idx] <= nxt_way(i_vic);
              res_r <= d_dat_r[d_slot];
              st_r <= scc_pkg::ST_DONE;
            end else if (cch_r) begin
              vw_r <= i_vic;
              ev_r[`SCC_IRQ_MISS] <= 1'b1;
              go_mem(1'b0, addr_r, `SCC_BE_ALL, wdat_r, scc_pkg::ST_FILL);
            end else begin
              go_mem(1'b0, addr_r, `SCC_BE_ALL, wdat_r, scc_pkg::ST_MEM);
            end
          end else if (d_hit && !cch_r) begin
            // Line present but access not cacheable
            vw_r <= d_way;
            fill_r <= 1'b0;
            if (d_dty_r[d_slot]) begin
              go_mem(1'b1, line_addr(a_tag, a_idx), `SCC_BE_ALL, d_dat_r[d_slot], scc_pkg::ST_WBACK);
            end else begin
              d_val_r[d_slot] <= 1'b0;
              go_mem(is_st, addr_r, unc_be, wdat_r, scc_pkg::ST_MEM);
            end
          end else if (d_hit) begin
            if (is_st) d_dat_r[d_slot] <= merge(d_dat_r[d_slot], wdat_r, be_r);
            if (is_st && is_wb) d_dty_r[d_slot] <= 1'b1;
            if (is_st && !is_wb) begin
              go_mem(1'b1, addr_r, be_r, wdat_r, scc_pkg::ST_MEM);
            end else begin
              res_r <= d_dat_r[d_slot];
              st_r <= scc_pkg::ST_DONE;
            end
          end else if (cch_r && (!is_st || is_wb)) begin
            vw_r <= d_vic;
            fill_r <= 1'b1;
            ev_r[`SCC_IRQ_MISS] <= 1'b1;
            if (d_vset[d_vic] && d_dty_r[dv_slot]) begin
              go_mem(1'b1, line_addr(d_tag_r[dv_slot], a_idx), `SCC_BE_ALL, d_dat_r[dv_slot],
                     scc_pkg::ST_WBACK);
            end else begin
              go_mem(1'b0, addr_r, `SCC_BE_ALL, wdat_r, scc_pkg::ST_FILL);
            end
          end else begin
            go_mem(is_st, addr_r, unc_be, wdat_r, scc_pkg::ST_MEM);
          end
        end
        scc_pkg::ST_WBACK: begin
          if (MEM_ACK) begin
            mem_req_r <= 1'b0;
            d_dty_r[v_slot] <= 1'b0;
            if (op_r == scc_pkg::OP_PROBE) begin
              if (inv_r) d_val_r[v_slot] <= 1'b0;
              prb_ack_r <= 1'b1;
              st_r <= scc_pkg::ST_IDLE;
            end else if (fill_r) begin
              go_mem(1'b0, addr_r, `SCC_BE_ALL, wdat_r, scc_pkg::ST_FILL);
            end else begin
              d_val_r[v_slot] <= 1'b0;
              go_mem(is_st, addr_r, unc_be, wdat_r, scc_pkg::ST_MEM);
            end
          end
        end
        scc_pkg::ST_FILL: begin
          if (MEM_ACK) begin
            mem_req_r <= 1'b0;
            res_r <= MEM_RDATA;
            rr_r[a_idx] <= nxt_way(vw_r);
            st_r <= scc_pkg::ST_DONE;
            if (op_r == scc_pkg::OP_FETCH) begin
              i_tag_r[v_slot] <= a_tag;
              i_dat_r[v_slot] <= MEM_RDATA;
              i_val_r[v_slot] <= 1'b1;
            end else begin
              d_tag_r[v_slot] <= a_tag;
              d_dat_r[v_slot] <= is_st ? merge(MEM_RDATA, wdat_r, be_r) : MEM_RDATA;
              d_val_r[v_slot] <= 1'b1;
              d_dty_r[v_slot] <= is_st;
            end
          end
        end
        scc_pkg::ST_MEM: begin
          if (MEM_ACK) begin
            mem_req_r <= 1'b0;
            res_r <= MEM_RDATA;
            st_r <= scc_pkg::ST_DONE;
            if (op_r == scc_pkg::OP_FETCH) begin
              pf_addr_r <= addr_r;
              pf_dat_r <= MEM_RDATA;
              pf_val_r <= 1'b1;
            end
          end
        end
        scc_pkg::ST_PROBE: begin
          // Answered whatever the global disable bit says
          prb_hit_r <= d_hit || i_hit;
          if (inv_r && i_hit) i_val_r[i_slot] <= 1'b0;
          if (d_hit && d_dty_r[d_slot]) begin
            vw_r <= d_way;
            ev_r[`SCC_IRQ_PWB] <= 1'b1;
            go_mem(1'b1, line_addr(a_tag, a_idx), `SCC_BE_ALL, d_dat_r[d_slot], scc_pkg::ST_WBACK);
          end else begin
            if (inv_r && d_hit) d_val_r[d_slot] <= 1'b0;
            prb_ack_r <= 1'b1;
            st_r <= scc_pkg::ST_IDLE;
          end
        end
        scc_pkg::ST_DONE: begin
          cpu_rdat_r <= res_r >> {a_ofs, 3'b000};
          cpu_ack_r <= 1'b1;
          st_r <= scc_pkg::ST_IDLE;
        end
        default: begin
          st_r <= scc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  wire apb_setup = PSEL && !PENABLE;
  wire apb_done = PSEL && PENABLE && pready_r;
  wire sel_ctrl = PADDR == `SCC_OFF_CTRL;
  wire sel_tb = PADDR == `SCC_OFF_TBASE;
  wire sel_rng = PADDR == `SCC_OFF_RANGE;
  wire sel_st = PADDR == `SCC_OFF_IRQST;
  wire sel_msk = PADDR == `SCC_OFF_IRQMSK;
  wire sel_stat = PADDR == `SCC_OFF_STAT;
  wire mapped = sel_ctrl || sel_tb || sel_rng || sel_st || sel_msk || sel_stat;
  wire bad_ctrl = PWRITE && sel_ctrl && !PWDATA[`SCC_BIT_CD] && PWDATA[`SCC_BIT_NW];
  wire wr_ok = apb_done && PWRITE && !pslverr_r;
  wire ev_fault = apb_done && PWRITE && sel_ctrl && pslverr_r;
  wire [31:0] stat_word = {miss_cnt_r, {(32 - MC_W - 3){1'b0}}, st_r};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_r : sel_tb ? tbase_r : sel_rng ? rng_r :
    sel_st ? 32'(irq_st_r) : sel_msk ? 32'(irq_msk_r) : sel_stat ? stat_word : '0;

  // Answer prepared in setup, so access ends without wait
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= apb_setup;
      if (apb_setup) begin
        prdata_r <= PWRITE ? '0 : rd_mux;
        pslverr_r <= !mapped || bad_ctrl;
      end
    end
  end

  // Software registers
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      ctrl_r <= `SCC_RST_CTRL;
      tbase_r <= `SCC_RST_TBASE;
      rng_r <= `SCC_RST_RANGE;
      irq_msk_r <= '0;
    end else if (wr_ok) begin
      if (sel_ctrl) ctrl_r <= PWDATA & `SCC_CTRL_MASK;
      if (sel_tb) tbase_r <= PWDATA;
      if (sel_rng) rng_r <= PWDATA & `SCC_RANGE_MASK;
      if (sel_msk) irq_msk_r <= PWDATA[IW-1:0];
    end
  end

  // ----------------------------------------
  // Interrupt status, cleared by reading
  // ----------------------------------------
  wire rd_st = apb_done && !PWRITE && sel_st;
  wire [IW-1:0] ev_all = ev_r | (IW'(ev_fault) << `SCC_IRQ_FAULT);
  wire [IW-1:0] st_clr = rd_st ? prdata_r[IW-1:0] : '0;

  // Only bits that were read get cleared; new events win
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      irq_st_r <= '0;
      miss_cnt_r <= '0;
    end else begin
      irq_st_r <= (irq_st_r & ~st_clr) | ev_all;
      miss_cnt_r <= miss_cnt_r + MC_W'(ev_r[`SCC_IRQ_MISS]);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign CPU_READY = (st_r == scc_pkg::ST_IDLE) && !PRB_REQ;
  assign CPU_ACK = cpu_ack_r;
  assign CPU_RDATA = cpu_rdat_r;
  assign PRB_READY = st_r == scc_pkg::ST_IDLE;
  assign PRB_ACK = prb_ack_r;
  assign PRB_HIT = prb_hit_r;
  assign MEM_REQ = mem_req_r;
  assign MEM_WE = mem_we_r;
  assign MEM_ADDR = mem_addr_r;
  assign MEM_BE = mem_be_r;
  assign MEM_WDATA = mem_wdat_r;
  assign IRQ = |(irq_st_r & irq_msk_r);
endmodule
